/* core/csp_consts.svh */
/*
  constants of the codec serial port: control register indices, reset values,
  field positions inside registers and serial words, divider decoding.
  assumes inclusion by name from the package and the design modules.
*/
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// control register count and indices (a to e)
`define CSP_CR_NUM      5
`define CSP_CR_A        3'h0
`define CSP_CR_B        3'h1
`define CSP_CR_C        3'h2
`define CSP_CR_D        3'h3
`define CSP_CR_E        3'h4

// control register reset values
`define CSP_RST_A       8'h00
`define CSP_RST_B       8'h00
`define CSP_RST_C       8'h00
`define CSP_RST_D       8'h00
`define CSP_RST_E       8'h00

// field positions
`define CSP_B_MDIV_LSB  0
`define CSP_B_SDIV_LSB  3
`define CSP_C_HREF_BIT  7
`define CSP_D_GAIN_LSB  0

// serial word layout
`define CSP_WORD_MSB    4'hf
`define CSP_W_CTL_BIT   15
`define CSP_W_RD_BIT    14
`define CSP_W_ADR_LSB   8

// serial clock divider base: half period = mdiv * (base << sdiv code)
`define CSP_SDIV_BASE   9'h004

`endif

/* core/csp_pkg.sv */
/*
  types of the codec serial port: state enums and the module state records.
  assumes csp_consts.svh is reachable by its bare name.
*/
`include "csp_consts.svh"

package csp_pkg;

  // transmit path, gray along idle -> sync -> shift
  typedef enum logic [1:0] {
    CSP_TX_IDLE  = 2'b00,
    CSP_TX_SYNC  = 2'b01,
    CSP_TX_SHIFT = 2'b11
  } csp_tx_t;

  // receive path
  typedef enum logic {
    CSP_RX_HUNT  = 1'b0,
    CSP_RX_SHIFT = 1'b1
  } csp_rx_t;

  typedef logic [`CSP_CR_NUM-1:0][7:0] csp_regs_t;

  // whole state of the serial engine
  typedef struct packed {
    logic [2:0]  en_s;     // port enable synchroniser
    logic        en;       // filtered port enable
    logic [2:0]  sd_in_s;  // data input synchroniser
    logic        sd_in;    // filtered data input
    logic [2:0]  ifs_s;    // frame input synchroniser
    logic        ifs;      // filtered frame input
    logic        sclk;     // bit clock level
    logic [8:0]  div;      // half period counter
    csp_tx_t     tx;       // transmit state
    logic [3:0]  tx_cnt;   // transmitted bit index
    logic [15:0] tx_sh;    // transmit shifter
    logic        sd_out;   // data output bit
    logic        ofs;      // output frame pulse
    csp_rx_t     rx;       // receive state
    logic [3:0]  rx_cnt;   // received bit index
    logic [15:0] rx_sh;    // receive shifter
    logic        rb_pend;  // register readback waiting
    logic [15:0] rb_word;  // readback word
    logic        adc_pend; // sample waiting
    logic [15:0] adc_word; // sample word
    logic [15:0] dac_data; // last received sample
    logic        dac_valid;// sample strobe
  } csp_state_t;

endpackage

/* core/csp_cr_if.sv */
/*
  carrier between the serial engine and the control register file.
  assumes one clock domain; the engine writes, the register file holds.
*/
`timescale 1ns/1ps
interface csp_cr_if;
  import csp_pkg::*;
  logic       we;    // write strobe
  logic [2:0] waddr; // register index
  logic [7:0] wdata; // write data
  csp_regs_t  regs;  // all register contents

  modport engine (output we, output waddr, output wdata, input regs);
  modport store  (input we, input waddr, input wdata, output regs);
endinterface

/* core/csp_ctrl_regs.sv */
/*
  control registers a to e of the codec serial port.
  assumes a synchronous write strobe from the serial engine on the same clock.
*/
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_ctrl_regs
  import csp_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // register access
  csp_cr_if.store   cr
);

  // whole state: the register array
  typedef struct packed {
    csp_regs_t regs;
  } csp_rf_t;

  csp_rf_t st;      // current contents
  csp_rf_t next_st; // next contents

  // write decode, unmapped indices are dropped
  always_comb
  begin
    next_st = st;
    if (cr.we && (cr.waddr < 3'(`CSP_CR_NUM)))
    begin
      next_st.regs[cr.waddr] = cr.wdata;
    end
  end

  // registers survive port disable, only reset clears them
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st.regs <= {`CSP_RST_E, `CSP_RST_D, `CSP_RST_C, `CSP_RST_B, `CSP_RST_A};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cr.regs = st.regs;

endmodule

/* core/csp_serial_port.sv */
/*
  digital side of the codec serial port: bit clock divider, framed 16-bit
  transmit and receive, control word decode into registers a to e.
  assumes the far side is a dsp serial port clocked by the bit clock made here,
  and an mclk of 10 MHz; pins from the dsp are treated as asynchronous.
*/
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_serial_port
  import csp_pkg::*;
(
  // clock and asynchronous reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // serial pins
  input  wire logic        port_enable_i,
  input  wire logic        serial_data_in_i,
  input  wire logic        in_frame_pulse_i,
  output logic             sclk_o,
  output logic             serial_data_out_o,
  output logic             serial_data_out_oe_o,
  output logic             out_frame_pulse_o,
  output logic             out_frame_pulse_oe_o,
  // converter side
  input  wire logic [15:0] adc_data_i,
  input  wire logic        adc_valid_i,
  output logic             adc_ready_o,
  output logic [15:0]      dac_data_o,
  output logic             dac_valid_o,
  // analog controls
  output logic             high_ref_select_o,
  output logic [2:0]       input_gain_o
);

  logic [1:0]  rst_s;    // reset release chain
  logic        rst_n;    // released reset
  csp_state_t  st;       // current state
  csp_state_t  next_st;  // next state
  logic [8:0]  half;     // bit clock half period in mclk cycles
  logic        rise_ev;  // bit clock rises at this edge
  logic        fall_ev;  // bit clock falls at this edge
  logic [15:0] rx_word;  // completed input word
  csp_cr_if    cr ();    // register carrier

  // assertions below share the master clock and the released reset
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  // register readout, unmapped indices read zero
  function automatic logic [7:0] cr_read(input csp_regs_t regs, input logic [2:0] idx);
    cr_read = (idx < 3'(`CSP_CR_NUM)) ? regs[idx] : 8'h00;
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s <= 2'h0;
    end
    else
    begin
      rst_s <= {rst_s[0], 1'b1};
    end
  end
  assign rst_n = rst_s[1];

  csp_ctrl_regs u_regs (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .cr      (cr.store)
  );

  // divider product: mdiv in 1..8, sclk ratio 8 << code, so half period >= 4
  always_comb
  begin
    half = 9'({5'h0, 4'({1'b0, cr.regs[`CSP_CR_B][`CSP_B_MDIV_LSB +: 3]}) + 4'h1})
           * (`CSP_SDIV_BASE << cr.regs[`CSP_CR_B][`CSP_B_SDIV_LSB +: 2]);
  end

  assign rise_ev = st.en && !st.sclk && (st.div == half - 9'h001);
  assign fall_ev = st.en && st.sclk && (st.div == half - 9'h001);
  assign rx_word = {st.rx_sh[14:0], st.sd_in};

  // next state
  always_comb
  begin
    next_st = st;
    cr.we = 1'b0;
    cr.waddr = rx_word[`CSP_W_ADR_LSB +: 3];
    cr.wdata = rx_word[7:0];
    next_st.dac_valid = 1'b0;
    // three-stage synchronisers, second and third must agree
    next_st.en_s = {st.en_s[1:0], port_enable_i};
    next_st.sd_in_s = {st.sd_in_s[1:0], serial_data_in_i};
    next_st.ifs_s = {st.ifs_s[1:0], in_frame_pulse_i};
    if (st.en_s[1] == st.en_s[2])
    begin
      next_st.en = st.en_s[2];
    end
    if (st.sd_in_s[1] == st.sd_in_s[2])
    begin
      next_st.sd_in = st.sd_in_s[2];
    end
    if (st.ifs_s[1] == st.ifs_s[2])
    begin
      next_st.ifs = st.ifs_s[2];
    end
    // new sample from the converter, one held at a time
    if (adc_valid_i && !st.adc_pend)
    begin
      next_st.adc_pend = 1'b1;
      next_st.adc_word = adc_data_i;
    end
    if (!st.en)
    begin
      // disabled: clock stopped, counters held at reset values, regs kept
      next_st.sclk = 1'b0;
      next_st.div = 9'h000;
      next_st.tx = CSP_TX_IDLE;
      next_st.tx_cnt = 4'h0;
      next_st.sd_out = 1'b0;
      next_st.ofs = 1'b0;
      next_st.rx = CSP_RX_HUNT;
      next_st.rx_cnt = 4'h0;
      next_st.rb_pend = 1'b0;
      next_st.adc_pend = 1'b0;
    end
    else
    begin
      // bit clock divider
      if (st.div == half - 9'h001)
      begin
        next_st.div = 9'h000;
        next_st.sclk = !st.sclk;
      end
      else
      begin
        next_st.div = st.div + 9'h001;
      end
      // transmit, moves only at the rising edge
      if (rise_ev)
      begin
        next_st.ofs = 1'b0;
        case (st.tx)
          CSP_TX_IDLE:
          begin
            if (st.rb_pend || st.adc_pend)
            begin
              next_st.ofs = 1'b1;
              next_st.tx = CSP_TX_SYNC;
            end
          end
          CSP_TX_SYNC:
          begin
            // msb goes out one period after the frame pulse
            next_st.tx_sh = st.rb_pend ? st.rb_word : st.adc_word;
            next_st.sd_out = st.rb_pend ? st.rb_word[15] : st.adc_word[15];
            next_st.rb_pend = 1'b0;
            next_st.adc_pend = st.rb_pend ? next_st.adc_pend : 1'b0;
            next_st.tx_cnt = 4'h0;
            next_st.tx = CSP_TX_SHIFT;
          end
          CSP_TX_SHIFT:
          begin
            if (st.tx_cnt == `CSP_WORD_MSB)
            begin
              next_st.tx = CSP_TX_IDLE;
            end
            else
            begin
              next_st.sd_out = st.tx_sh[14];
              next_st.tx_sh = {st.tx_sh[14:0], 1'b0};
              next_st.tx_cnt = st.tx_cnt + 4'h1;
            end
          end
          default:
          begin
            next_st.tx = CSP_TX_IDLE;
          end
        endcase
      end
      // receive, samples only at the falling edge
      if (fall_ev)
      begin
        case (st.rx)
          CSP_RX_HUNT:
          begin
            // relies on the dsp pulsing one period ahead of the msb
            if (st.ifs)
            begin
              next_st.rx = CSP_RX_SHIFT;
              next_st.rx_cnt = 4'h0;
            end
          end
          CSP_RX_SHIFT:
          begin
            next_st.rx_sh = rx_word;
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            if (st.rx_cnt == `CSP_WORD_MSB)
            begin
              next_st.rx = CSP_RX_HUNT;
              if (!rx_word[`CSP_W_CTL_BIT])
              begin
                next_st.dac_data = rx_word;
                next_st.dac_valid = 1'b1;
              end
              else if (rx_word[`CSP_W_RD_BIT])
              begin
                // readback echoes the header with the register contents
                next_st.rb_word = {rx_word[15:8], cr_read(cr.regs, cr.waddr)};
                next_st.rb_pend = 1'b1;
              end
              else
              begin
                cr.we = 1'b1;
              end
            end
          end
          default:
          begin
            next_st.rx = CSP_RX_HUNT;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs
  assign sclk_o = st.sclk;
  assign serial_data_out_o = st.sd_out;
  assign serial_data_out_oe_o = st.en && (st.tx == CSP_TX_SHIFT);
  assign out_frame_pulse_o = st.ofs;
  assign out_frame_pulse_oe_o = st.en;
  assign adc_ready_o = !st.adc_pend;
  assign dac_data_o = st.dac_data;
  assign dac_valid_o = st.dac_valid;
  assign high_ref_select_o = cr.regs[`CSP_CR_C][`CSP_C_HREF_BIT];
  assign input_gain_o = cr.regs[`CSP_CR_D][`CSP_D_GAIN_LSB +: 3];

  // a disable landing on the sync edge legally floats the msb
  ofs_one_period_a: assert property (
    (st.tx == CSP_TX_SYNC && rise_ev) |=> (!st.ofs && (serial_data_out_oe_o || !st.en)))
    else $error("frame pulse not followed by msb");
  ofs_at_rise_a: assert property (
    $changed(st.ofs) |-> ($past(rise_ev) || !$past(st.en)))
    else $error("frame pulse moved off a rising edge");
  dout_at_rise_a: assert property (
    $changed(st.sd_out) |-> ($past(rise_ev) || !$past(st.en)))
    else $error("data output moved off a rising edge");
  // the drive may only be released after the last bit or by a disable
  dout_idle_hiz_a: assert property (
    $fell(serial_data_out_oe_o) |-> (!st.en || $past(st.tx_cnt) == `CSP_WORD_MSB))
    else $error("data output released in mid word");
  disabled_quiet_a: assert property (
    (!st.en && !$past(st.en)) |-> (!serial_data_out_oe_o && !out_frame_pulse_oe_o && !sclk_o))
    else $error("port active while disabled");
  rx_at_fall_a: assert property (
    $changed(st.rx_sh) |-> $past(fall_ev))
    else $error("input bit taken off a falling edge");
  ifs_starts_rx_a: assert property (
    (fall_ev && st.rx == CSP_RX_HUNT && st.ifs) |=> (st.rx == CSP_RX_SHIFT && st.rx_cnt == 4'h0))
    else $error("input frame pulse missed");
  reenable_fresh_a: assert property (
    $rose(st.en) |-> (st.tx == CSP_TX_IDLE && st.rx == CSP_RX_HUNT && st.div == 9'h000))
    else $error("counters not fresh on re-enable");
  regs_kept_a: assert property (
    !st.en |=> $stable(cr.regs))
    else $error("registers changed while disabled");
  en_sync_a: assert property (
    $changed(st.en) |-> (st.en == $past(st.en_s[2]) && $past(st.en_s[1]) == $past(st.en_s[2])))
    else $error("enable taken before synchroniser agreed");
  sclk_high_min_a: assert property (
    $rose(sclk_o) |-> (sclk_o || !st.en) [*4])
    else $error("bit clock high phase too short");
  word_end_a: assert property (
    (st.tx == CSP_TX_SHIFT && rise_ev && st.tx_cnt == 4'hf) |=> !serial_data_out_oe_o)
    else $error("word longer than sixteen bits");

endmodule

/* dv/csp_dsp_model.sv */
/*
  dsp serial port model facing the codec serial port.
  assumes the codec makes the bit clock; words go out on its rise, in on its fall.
*/
`timescale 1ns/1ps
module csp_dsp_model
(
  // bit clock from the codec
  input  wire logic        sclk_i,
  // codec outputs
  input  wire logic        sd_out_i,
  input  wire logic        sd_out_oe_i,
  input  wire logic        ofs_i,
  // dsp outputs
  output logic             sd_in_o,
  output logic             ifs_o,
  // last word received and word count
  output logic [15:0]      rx_word_o,
  output int               rx_n_o
);
  logic        busy;    // a word is being sent
  logic [15:0] rx_sh;   // receive shifter
  int          rx_left; // bits still to receive

  initial
  begin
    busy = 1'b0;
    sd_in_o = 1'b0;
    ifs_o = 1'b0;
    rx_word_o = 16'h0000;
    rx_n_o = 0;
    rx_left = 0;
  end

  // frame pulse one period ahead, then msb first, sixteen bits
  task automatic send_word(input logic [15:0] w);
    busy = 1'b1;
    @(posedge sclk_i);
    ifs_o <= 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge sclk_i);
      ifs_o <= 1'b0;
      sd_in_o <= w[i];
    end
    @(posedge sclk_i);
    busy = 1'b0;
  endtask

  // idle data line keeps changing so a stale bit is never mistaken for data
  always @(posedge sclk_i)
  begin
    if (!busy)
      sd_in_o <= ~sd_in_o;
  end

  // capture on the fall; a dropped enable mid-word shows as unknown bits
  always @(negedge sclk_i)
  begin
    if (rx_left > 0)
    begin
      rx_sh <= {rx_sh[14:0], (sd_out_oe_i ? sd_out_i : 1'bx)};
      rx_left <= rx_left - 1;
      if (rx_left == 1)
      begin
        rx_word_o <= {rx_sh[14:0], (sd_out_oe_i ? sd_out_i : 1'bx)};
        rx_n_o <= rx_n_o + 1;
      end
    end
    else if (ofs_i === 1'b1)
      rx_left <= 16;
  end
endmodule

/* dv/codec_serial_port_control_bench.sv */
/*
  self-checking bench of the codec serial port with a dsp model on the pins.
  assumes a 10 MHz mclk and the reset register values of zero.
*/
`timescale 1ns/1ps
module codec_serial_port_control_bench;
  import csp_pkg::*;
  logic        mclk, arst_n, port_enable, adc_valid;  // driven inputs
  logic [15:0] adc_data;                              // sample to send
  logic        sd_in, ifs, sclk, sd_out, sd_out_oe, ofs, ofs_oe;
  logic        adc_ready, dac_valid, high_ref;
  logic [15:0] dac_data, rx_word;
  logic [2:0]  gain;
  int          rx_n, dac_n;                           // word counters
  int          n_errors, samples_checked;

  csp_serial_port u_dut (.mclk_i(mclk), .arst_n_i(arst_n), .port_enable_i(port_enable),
    .serial_data_in_i(sd_in), .in_frame_pulse_i(ifs), .sclk_o(sclk),
    .serial_data_out_o(sd_out), .serial_data_out_oe_o(sd_out_oe), .out_frame_pulse_o(ofs),
    .out_frame_pulse_oe_o(ofs_oe), .adc_data_i(adc_data), .adc_valid_i(adc_valid),
    .adc_ready_o(adc_ready), .dac_data_o(dac_data), .dac_valid_o(dac_valid),
    .high_ref_select_o(high_ref), .input_gain_o(gain));

  csp_dsp_model u_dsp (.sclk_i(sclk), .sd_out_i(sd_out), .sd_out_oe_i(sd_out_oe), .ofs_i(ofs),
    .sd_in_o(sd_in), .ifs_o(ifs), .rx_word_o(rx_word), .rx_n_o(rx_n));

  // 100 ns master clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // count one-cycle sample strobes, looked at mid cycle where they are settled
  always @(negedge mclk)
  begin
    if (dac_valid === 1'b1)
      dac_n++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait for the model to finish a word
  task automatic wait_rx(input int n0);
    for (int i = 0; i < 3000 && rx_n == n0; i++)
      @(negedge mclk);
  endtask

  // bit clock period in mclk cycles, one period skipped to settle
  task automatic period(output int p);
    realtime t0;
    @(posedge sclk);
    @(posedge sclk);
    t0 = $realtime;
    @(posedge sclk);
    p = int'(($realtime - t0) / 100.0);
  endtask

  // send a read word and compare the reply
  task automatic read_chk(input logic [15:0] cmd, input logic [15:0] exp);
    int n0;
    n0 = rx_n;
    u_dsp.send_word(cmd);
    wait_rx(n0);
    check("readback", rx_word, exp);
  endtask

  task automatic t_reset;
    check("data_oe", 16'(sd_out_oe), 16'h0000);
    check("ofs_oe", 16'(ofs_oe), 16'h0000);
    check("sclk", 16'(sclk), 16'h0000);
    check("adc_ready", 16'(adc_ready), 16'h0001);
    check("cfg", 16'({high_ref, gain}), 16'h0000);
    port_enable = 1'b1;
    repeat (2) @(negedge mclk);
    check("sclk_sync", 16'(sclk), 16'h0000);
    repeat (20) @(negedge mclk);
  endtask

  task automatic t_clock;
    int p;
    period(p);
    check("period_rst", 16'(p), 16'h0008);
    check("idle_oe", 16'(sd_out_oe), 16'h0000);
    u_dsp.send_word(16'h8101);
    period(p);
    check("period_div", 16'(p), 16'h0010);
  endtask

  task automatic t_regs;
    u_dsp.send_word(16'h8280);
    u_dsp.send_word(16'h8305);
    repeat (4) @(negedge mclk);
    check("high_ref", 16'(high_ref), 16'h0001);
    check("gain", 16'(gain), 16'h0005);
    read_chk(16'hc200, 16'hc280);
    read_chk(16'hc300, 16'hc305);
    read_chk(16'hc500, 16'hc500);
  endtask

  task automatic t_data;
    int d0;
    d0 = dac_n;
    u_dsp.send_word(16'h1234);
    repeat (4) @(negedge mclk);
    check("dac_data", dac_data, 16'h1234);
    u_dsp.send_word(16'h4001);
    repeat (4) @(negedge mclk);
    check("dac_data2", dac_data, 16'h4001);
    check("dac_pulses", 16'(dac_n - d0), 16'h0002);
  endtask

  // one sample from the converter, compared with the word the model receives
  task automatic t_adc(input logic [15:0] w);
    int n0;
    n0 = rx_n;
    adc_data = w;
    adc_valid = 1'b1;
    for (int i = 0; i < 2000 && adc_ready !== 1'b0; i++)
      @(negedge mclk);
    adc_valid = 1'b0;
    wait_rx(n0);
    check("adc_word", rx_word, w);
  endtask

  task automatic t_disable;
    int hi;
    int p;
    hi = 0;
    port_enable = 1'b0;
    repeat (10) @(negedge mclk);
    check("dis_data_oe", 16'(sd_out_oe), 16'h0000);
    check("dis_ofs_oe", 16'(ofs_oe), 16'h0000);
    repeat (64)
    begin
      @(negedge mclk);
      hi += (sclk !== 1'b0);
    end
    check("sclk_stop", 16'(hi), 16'h0000);
    port_enable = 1'b1;
    repeat (10) @(negedge mclk);
    check("kept_cfg", 16'({high_ref, gain}), 16'h000d);
    period(p);
    check("kept_div", 16'(p), 16'h0010);
    check("reen_oe", 16'(sd_out_oe), 16'h0000);
    read_chk(16'hc200, 16'hc280);
  endtask

  initial
  begin
    arst_n = 1'b0;
    port_enable = 1'b0;
    adc_valid = 1'b0;
    adc_data = 16'h0000;
    n_errors = 0;
    samples_checked = 0;
    dac_n = 0;
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_clock();
    t_regs();
    t_data();
    t_adc(16'ha5c3);
    t_adc(16'h0001);
    t_disable();
    end_sim();
  end

  // watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    end_sim();
  end
endmodule
